// ### bfw_defs.vh
/*
 bus-fault stack frame writer constants: frame offsets, format codes, sizes.
 assumes byte offsets from the supervisor stack pointer, word = 16 bits.
*/
`ifndef BFW_DEFS_VH
`define BFW_DEFS_VH

// format codes in the upper nibble of the format/vector word
`define BFW_FMT_SHORT 4'ha
`define BFW_FMT_LONG 4'hb

// frame sizes in 16-bit words
`define BFW_SHORT_WORDS 7'h10
// long frame: up to the version word at $38 plus 18 opaque words, 47 words without the pad to a whole long word
`define BFW_LONG_WORDS 7'h2f
`define BFW_INT_STATE_WORDS 5'h12

// byte offsets from the stack pointer
`define BFW_OFS_SR 8'h00
`define BFW_OFS_PC 8'h02
`define BFW_OFS_FMT 8'h06
`define BFW_OFS_FSW 8'h0a
`define BFW_OFS_PIPE_C 8'h0c
`define BFW_OFS_PIPE_B 8'h0e
`define BFW_OFS_FADDR 8'h10
`define BFW_OFS_DOB 8'h18
`define BFW_OFS_STB_ADDR 8'h24
`define BFW_OFS_DIB 8'h2c
`define BFW_OFS_VERSION 8'h38
`define BFW_OFS_INT_STATE 8'h3a

// fault status word bit carrying the data fault rerun flag
`define BFW_FSW_DF_BIT 8

// arbitrary neutral version code
`define BFW_VERSION 4'h1

`endif

// ### bfw_frame_writer.v
/*
 bfw_frame_writer: builds the short or long bus-fault stack frame and writes it
 to the supervisor stack as long words; restores a long frame and reports the
 data-fault rerun request.
 assumes a simple memory port: req/we/addr/wdata, one-cycle ack with rdata.
*/
`timescale 1ns/100ps
`default_nettype none
`include "bfw_defs.vh"

module bfw_frame_writer (
	// clock and reset
	input wire core_clk,
	input wire nrst,
	// fault from the core
	input wire fault_start,
	input wire mid_instr,
	input wire [31:0] sp_in,
	input wire [15:0] sr_in,
	input wire [31:0] pc_next,
	input wire [31:0] pc_exec,
	input wire [11:0] vector_offset,
	input wire [15:0] fault_status_word,
	input wire [15:0] pipe_c,
	input wire [15:0] pipe_b,
	input wire [31:0] fault_addr,
	input wire [31:0] data_out_buf,
	input wire [31:0] stage_b_addr,
	input wire [31:0] data_in_buf,
	input wire [11:0] version_info,
	input wire [287:0] int_state_in,
	// restore request from the core
	input wire restore_start,
	// memory port to the supervisor stack
	output reg mem_req_ff,
	output reg mem_we_ff,
	output reg [31:0] mem_addr_ff,
	output reg [31:0] mem_wdata_ff,
	input wire mem_ack,
	input wire [31:0] mem_rdata,
	// status to the core
	output reg busy_ff,
	output reg done_ff,
	output reg rerun_data_ff,
	output reg [287:0] int_state_out_ff
);

localparam NLW = 24;
localparam S_IDLE = 4'b0001;
localparam S_WR = 4'b0010;
localparam S_RD = 4'b0100;
localparam S_DONE = 4'b1000;

reg [3:0] state_ff;
reg [3:0] nxt_state;
reg [4:0] idx_ff;
reg long_ff;
reg [NLW*32-1:0] img_ff;
reg [15:0] fsw_rd_ff;
reg [NLW*32-1:0] img;
wire [31:0] cur_word;
wire [4:0] last_idx;
wire [4:0] nxt_idx;
wire [15:0] fmt_word;
integer k;

////////////////////////////////////////////////////////////////////////////////
// frame image, long word i lives at byte offset 4*i

assign fmt_word = {(mid_instr ? `BFW_FMT_LONG : `BFW_FMT_SHORT), vector_offset};
// short frame ends after 8 long words, long frame after 24
assign last_idx = long_ff ? 5'd23 : 5'd7;
assign nxt_idx = idx_ff + 5'd1;

always @* begin
	img = {NLW*32{1'b0}};
	// sr at 00, pc at 02..05 straddles long words 0 and 1
	img[0*32 +: 32] = {sr_in, mid_instr ? pc_exec[31:16] : pc_next[31:16]};
	img[1*32 +: 32] = {mid_instr ? pc_exec[15:0] : pc_next[15:0], fmt_word};
	img[2*32 +: 32] = {16'h0, fault_status_word};
	img[3*32 +: 32] = {pipe_c, pipe_b};
	img[4*32 +: 32] = fault_addr;
	img[6*32 +: 32] = data_out_buf;
	img[9*32 +: 32] = stage_b_addr;
	img[11*32 +: 32] = data_in_buf;
	// version word at $38, then 18 opaque words from $3a
	img[14*32 +: 32] = {`BFW_VERSION, version_info, int_state_in[287:272]};
	for (k = 0; k < 8; k = k + 1) begin
		img[(15+k)*32 +: 32] = int_state_in[k*32 +: 32];
	end
	// eighteenth opaque word; the low half only pads the last long word
	img[23*32 +: 32] = {int_state_in[271:256], 16'h0};
end

bfw_word_mux #(.N(NLW)) u_mux (
	.frame(img_ff),
	.idx(nxt_idx),
	.word(cur_word)
);

////////////////////////////////////////////////////////////////////////////////
// sequencer: ascending long-word order, one word per acknowledged cycle

always @* begin
	nxt_state = state_ff;
	case (state_ff)
		S_IDLE: begin
			if (fault_start) begin
				nxt_state = S_WR;
			end else if (restore_start) begin
				nxt_state = S_RD;
			end
		end
		S_WR: begin
			if (mem_ack && idx_ff == last_idx) begin
				nxt_state = S_DONE;
			end
		end
		S_RD: begin
			if (mem_ack && idx_ff == 5'd23) begin
				nxt_state = S_DONE;
			end
		end
		S_DONE: begin
			nxt_state = S_IDLE;
		end
		default: begin
			nxt_state = S_IDLE;
		end
	endcase
end

always @(posedge core_clk or negedge nrst) begin
	if (!nrst) begin
		state_ff <= S_IDLE;
		idx_ff <= 5'h0;
		long_ff <= 1'b0;
		img_ff <= {NLW*32{1'b0}};
		fsw_rd_ff <= 16'h0;
		mem_req_ff <= 1'b0;
		mem_we_ff <= 1'b0;
		mem_addr_ff <= 32'h0;
		mem_wdata_ff <= 32'h0;
		busy_ff <= 1'b0;
		done_ff <= 1'b0;
		rerun_data_ff <= 1'b0;
		int_state_out_ff <= 288'h0;
	end else begin
		state_ff <= nxt_state;
		done_ff <= 1'b0;
		case (state_ff)
			S_IDLE: begin
				idx_ff <= 5'h0;
				if (fault_start) begin
					// capture everything at once; sources may move on afterwards
					img_ff <= img;
					long_ff <= mid_instr;
					// stale restore status must not flag a rerun after a write
					fsw_rd_ff <= 16'h0;
					busy_ff <= 1'b1;
					rerun_data_ff <= 1'b0;
					mem_req_ff <= 1'b1;
					mem_we_ff <= 1'b1;
					mem_addr_ff <= sp_in;
					mem_wdata_ff <= img[31:0];
				end else if (restore_start) begin
					long_ff <= 1'b1;
					busy_ff <= 1'b1;
					rerun_data_ff <= 1'b0;
					mem_req_ff <= 1'b1;
					mem_we_ff <= 1'b0;
					mem_addr_ff <= sp_in;
				end
			end
			S_WR: begin
				if (mem_ack) begin
					idx_ff <= idx_ff + 5'd1;
					mem_addr_ff <= mem_addr_ff + 32'h4;
					if (idx_ff == last_idx) begin
						mem_req_ff <= 1'b0;
						mem_we_ff <= 1'b0;
					end else begin
						mem_wdata_ff <= cur_word;
					end
				end
			end
			S_RD: begin
				if (mem_ack) begin
					idx_ff <= idx_ff + 5'd1;
					mem_addr_ff <= mem_addr_ff + 32'h4;
					if (idx_ff == 5'd2) begin
						fsw_rd_ff <= mem_rdata[15:0];
					end
					// opaque words come back bit for bit
					if (idx_ff == 5'd14) begin
						int_state_out_ff[287:272] <= mem_rdata[15:0];
					end
					if (idx_ff >= 5'd15 && idx_ff <= 5'd22) begin
						int_state_out_ff[(idx_ff-5'd15)*32 +: 32] <= mem_rdata;
					end
					if (idx_ff == 5'd23) begin
						int_state_out_ff[271:256] <= mem_rdata[31:16];
						mem_req_ff <= 1'b0;
					end
				end
			end
			S_DONE: begin
				busy_ff <= 1'b0;
				done_ff <= 1'b1;
				if (!mem_we_ff && long_ff && fsw_rd_ff[`BFW_FSW_DF_BIT]) begin
					rerun_data_ff <= 1'b1;
				end
			end
			default: begin
				busy_ff <= 1'b0;
			end
		endcase
	end
end

endmodule // bfw_frame_writer

`default_nettype wire

// ### bfw_frame_writer_bench.sv
/* bench: short, long and restore frames; assumes bfw_mem_model as the stack */
`timescale 1ns/100ps
`default_nettype none
`include "bfw_defs.vh"
module bfw_frame_writer_bench;
	logic core_clk = 1'b0, nrst = 1'b0, fault_start = 1'b0, restore_start = 1'b0;
	logic mid_instr = 1'b0, slow = 1'b0, req, we, ack, busy, done, rerun;
	logic [31:0] addr, wdata, rdata, pcn = 32'h4a10, pce = 32'h4a08, fa = 32'h8ffe;
	logic [31:0] dob = 32'h1234_5678, sba = 32'h4a0c, dib = 32'h9abc_def0;
	logic [31:0] sp = 32'h1000;
	logic [15:0] sr = 16'h2700, fsw = 16'h0100, pc_c = 16'h4e71, pc_b = 16'h4e75;
	logic [11:0] vec = 12'h008, ver = 12'h0a5;
	logic [287:0] ist = {4{72'h0123456789abcdef5a}}, iso;
	int error_cnt = 0, checked = 0, cyc = 0;
	bfw_frame_writer bfw_frame_writer_inst (.core_clk, .nrst, .fault_start, .mid_instr,
		.sp_in(sp), .sr_in(sr), .pc_next(pcn), .pc_exec(pce), .vector_offset(vec),
		.fault_status_word(fsw), .pipe_c(pc_c), .pipe_b(pc_b), .fault_addr(fa),
		.data_out_buf(dob), .stage_b_addr(sba), .data_in_buf(dib), .version_info(ver),
		.int_state_in(ist), .restore_start, .mem_req_ff(req), .mem_we_ff(we),
		.mem_addr_ff(addr), .mem_wdata_ff(wdata), .mem_ack(ack), .mem_rdata(rdata),
		.busy_ff(busy), .done_ff(done), .rerun_data_ff(rerun), .int_state_out_ff(iso));
	bfw_mem_model bfw_mem_model_inst (.core_clk, .slow, .req, .we, .addr, .wdata,
		.ack_ff(ack), .rdata_ff(rdata));
	initial forever #12.5 core_clk = !core_clk;
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s exp %h got %h", s, e, g);
		end
	endtask
	// start is held two cycles: the second cycle must be ignored while busy
	task automatic go(input logic rs, input logic mi, input logic [31:0] base);
		int n = 0;
		@(posedge core_clk);
		sp <= base;
		fault_start <= !rs;
		restore_start <= rs;
		mid_instr <= mi;
		repeat (2) @(posedge core_clk);
		fault_start <= 1'b0;
		restore_start <= 1'b0;
		while (done !== 1'b1 && n < 300) begin
			@(negedge core_clk);
			n++;
		end
		chk("done", 32'h1, {31'h0, done});
		@(negedge core_clk);
		chk("busy", 32'h0, {31'h0, busy});
	endtask
	// short frame at base 10c0: long words land at m[48] and up
	task automatic short_frame();
		go(1'b0, 1'b0, 32'h10c0);
		chk("w0", {sr, pcn[31:16]}, bfw_mem_model_inst.m[48]);
		chk("w1", {pcn[15:0], 4'ha, vec}, bfw_mem_model_inst.m[49]);
		chk("fsw", {16'h0, fsw}, {16'h0, bfw_mem_model_inst.m[50][15:0]});
		chk("pipe", {pc_c, pc_b}, bfw_mem_model_inst.m[51]);
		chk("fa", fa, bfw_mem_model_inst.m[52]);
		chk("dob", dob, bfw_mem_model_inst.m[54]);
		chk("w8", 32'hffff_ffff, bfw_mem_model_inst.m[56]);
	endtask
	task automatic long_frame();
		slow <= 1'b1;
		go(1'b0, 1'b1, 32'h1000);
		slow <= 1'b0;
		chk("w1", {pce[15:0], 4'hb, vec}, bfw_mem_model_inst.m[1]);
		chk("w0", {sr, pce[31:16]}, bfw_mem_model_inst.m[0]);
		chk("fa", fa, bfw_mem_model_inst.m[4]);
		chk("ver", {`BFW_VERSION, ver, ist[287:272]}, bfw_mem_model_inst.m[14]);
		chk("int17", {ist[271:256], 16'h0}, bfw_mem_model_inst.m[23]);
	endtask
	task automatic restore_frame();
		go(1'b1, 1'b0, 32'h1000);
		chk("rerun", 32'h1, {31'h0, rerun});
		checked++;
		if (iso !== ist) begin
			error_cnt++;
			$display("wrong value int_state exp %h got %h", ist, iso);
		end
		// a write after a flagged restore must not ask for a rerun
		go(1'b0, 1'b1, 32'h1000);
		chk("rerun", 32'h0, {31'h0, rerun});
		bfw_mem_model_inst.m[2][8] = 1'b0;
		go(1'b1, 1'b0, 32'h1000);
		chk("rerun", 32'h0, {31'h0, rerun});
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			print_verdict();
		end
	end
	initial begin
		repeat (8) @(posedge core_clk);
		nrst <= 1'b1;
		short_frame();
		long_frame();
		restore_frame();
		print_verdict();
	end
endmodule // bfw_frame_writer_bench
`default_nettype wire

// ### bfw_frame_writer_properties.sv
/* port checker for bfw_frame_writer; bound after the module */
`timescale 1ns/100ps
`default_nettype none
module bfw_chk (
	input wire core_clk,
	input wire nrst,
	input wire fault_start,
	input wire restore_start,
	input wire [31:0] sp_in,
	input wire mem_req_ff,
	input wire mem_we_ff,
	input wire [31:0] mem_addr_ff,
	input wire [31:0] mem_wdata_ff,
	input wire mem_ack,
	input wire busy_ff,
	input wire done_ff
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	wire go = (fault_start | restore_start) & !busy_ff;
	a_start_base: assert property (go |=> mem_req_ff && mem_addr_ff == $past(sp_in))
		else $error("bad start");
	a_start_dir: assert property (go |=> mem_we_ff == $past(fault_start))
		else $error("bad direction");
	a_addr_step: assert property (mem_req_ff && mem_ack |=>
		!mem_req_ff || mem_addr_ff == $past(mem_addr_ff) + 32'h4)
		else $error("bad step");
	a_req_hold: assert property (mem_req_ff && !mem_ack |=>
		mem_req_ff && $stable(mem_addr_ff) && $stable(mem_wdata_ff))
		else $error("request moved");
	a_done_pulse: assert property (done_ff |=> !done_ff)
		else $error("long done");
	a_done_idle: assert property (done_ff |-> !busy_ff && !mem_req_ff)
		else $error("done while busy");
	a_idle_quiet: assert property (!busy_ff |-> !mem_req_ff)
		else $error("request while idle");
	a_done_after: assert property (mem_req_ff && mem_ack ##1 !mem_req_ff |-> ##[0:1] done_ff)
		else $error("no done");
endmodule // bfw_chk
bind bfw_frame_writer bfw_chk bfw_chk_inst (.core_clk(core_clk), .nrst(nrst),
	.fault_start(fault_start), .restore_start(restore_start), .sp_in(sp_in),
	.mem_req_ff(mem_req_ff), .mem_we_ff(mem_we_ff), .mem_addr_ff(mem_addr_ff),
	.mem_wdata_ff(mem_wdata_ff), .mem_ack(mem_ack), .busy_ff(busy_ff), .done_ff(done_ff));
`default_nettype wire

// ### bfw_mem_model.sv
/* stack memory model, 64 long words; assumes one clock, ack slowed when slow=1 */
`timescale 1ns/100ps
`default_nettype none
module bfw_mem_model (
	// clock and mode
	input wire logic core_clk,
	input wire logic slow,
	// memory port
	input wire logic req,
	input wire logic we,
	input wire logic [31:0] addr,
	input wire logic [31:0] wdata,
	output logic ack_ff,
	output logic [31:0] rdata_ff
);
	logic [31:0] m [0:63];
	logic tgl_ff = 1'b0;
	wire take = req && !ack_ff && (!slow || tgl_ff);
	initial begin
		for (int i = 0; i < 64; i++) m[i] = 32'hffff_ffff;
		ack_ff = 1'b0;
		rdata_ff = 32'h0;
	end
	// read data toggles while not acked, so a stale value never looks valid
	always @(posedge core_clk) begin
		tgl_ff <= !tgl_ff;
		ack_ff <= take;
		rdata_ff <= ~rdata_ff;
		if (take) begin
			rdata_ff <= m[addr[7:2]];
			if (we) m[addr[7:2]] <= wdata;
		end
	end
endmodule // bfw_mem_model
`default_nettype wire

// ### bfw_word_mux.v
/*
 bfw_word_mux: picks one 32-bit long word of the frame by its long-word index.
 assumes the frame image is flattened, long word 0 in the lowest bits.
*/
`timescale 1ns/100ps
`default_nettype none

module bfw_word_mux #(
	parameter N = 23
) (
	// frame image
	input wire [N*32-1:0] frame,
	// selection
	input wire [4:0] idx,
	output reg [31:0] word
);

integer i;

always @* begin
	word = 32'h0;
	for (i = 0; i < N; i = i + 1) begin
		if (idx == i[4:0]) begin
			word = frame[i*32 +: 32];
		end
	end
end

endmodule // bfw_word_mux

`default_nettype wire
